// File: rtl/gtpm_timing.sv
`timescale 1ns/1ps
// Summary of operation
// [R1] Two independent pulse outputs, rate set anywhere 0.25 Hz to 10 MHz; the code gives only 25 MHz / half_period, half_period 2 or more.
// [R2] Each pulse aligns to civil or satellite time scale.
// [R3] Pulses from clock; below 2 Hz next pulse phase reported beforehand.
// [R4] Reported time refers to the preceding pulse instant.
// [R5] Both edges of both event inputs stamped, counted and reported.
// [R6] Stamps resolve finer than one microsecond.
// [R7] Event stamps use the primary pulse's time scale.
// [R8] Uncertainty compared with accuracy limit; pulses gated off on failure.
// [R9] Uncertainty includes unresolved epoch, bit and sub-frame ambiguities.
// [R10] No pulses during duty-cycle off phase.
// [R11] After reset primary pulse enabled at one pulse per second.
// [R12] Outside circuitry must not hold secondary pulse pin low at start-up.
// [R13] Time mode disabled, survey-in then auto fixed, or entered fixed.
// [R14] Single-signal timing only in fixed mode.
// [R15] Integrity flag set when signals in use exceed required minimum.
// [R16] Aiding pulse on event input plus aiding message resolve ambiguity; the code clears the ambiguity terms on the aiding message alone.
// [R17] Separate wrapping rise and fall counters per event input.
// [R18] Disabled outputs held at inactive low level.
module gtpm_timing (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic ce,
  input wire logic [3:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [31:0] rdata,
  input wire logic event_input_a,
  input wire logic event_input_b,
  input wire logic duty_off,
  input wire logic time_aiding_msg,
  input wire logic [2:0] amb_flags,
  output logic primary_pulse_out,
  output logic secondary_pulse_out,
  output logic phase_report,
  output logic integrity_active,
  output logic irq
);
  logic [31:0] ctrl_r;
  logic [31:0] per0_r;
  logic [31:0] per1_r;
  logic [31:0] unc_r;
  logic [31:0] limit_r;
  logic [7:0] sig_used_r;
  logic [7:0] sig_min_r;
  logic [31:0] time_r;
  logic [31:0] pulse_time_r;
  logic [4:0] irq_st_r;
  logic [4:0] irq_en_r;
  logic [1:0] mode_r;
  logic [31:0] ts_r [4];
  logic [7:0] cnt_r [4];
  logic [1:0] ev_s1_r;
  logic [1:0] ev_s2_r;
  logic [1:0] ev_d_r;
  logic [31:0] unc_tot;
  logic gate_ok;
  logic run0;
  logic run1;
  logic p0;
  logic p1;
  logic r0;
  logic r1;
  logic fixed_ev;
  gtpm_pkg::gtpm_edge_s [1:0] ev_edge;

  function automatic logic [31:0] scale_time(input logic utc, input logic [31:0] t);
    scale_time = utc ? t - gtpm_pkg::UTC_OFS : t;
  endfunction : scale_time

  // Register writes and time-mode control
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ctrl_r <= gtpm_pkg::CTRL_RST; // see [R11]
      per0_r <= gtpm_pkg::PER_1HZ; // see [R11]
      per1_r <= gtpm_pkg::PER_1HZ;
      unc_r <= '0;
      limit_r <= 32'hFFFF_FFFF;
      sig_used_r <= 8'h04; // Default count keeps the 1 Hz pulse ungated, see [R11]
      sig_min_r <= 8'h04;
      irq_en_r <= '0;
    end else if (ce && wr) begin
      case (addr)
        gtpm_pkg::A_CTRL: ctrl_r <= wdata;
        gtpm_pkg::A_PER0: per0_r <= wdata; // see [R1]
        gtpm_pkg::A_PER1: per1_r <= wdata; // see [R1]
        gtpm_pkg::A_UNC: unc_r <= wdata;
        gtpm_pkg::A_LIMIT: limit_r <= wdata;
        gtpm_pkg::A_SIG: begin
          sig_used_r <= wdata[7:0];
          sig_min_r <= wdata[15:8];
        end
        gtpm_pkg::A_IRQ_EN: irq_en_r <= wdata[4:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      mode_r <= gtpm_pkg::GTPM_DISABLED;
    end else if (ce) begin
      case (mode_r)
        gtpm_pkg::GTPM_DISABLED: begin
          if (ctrl_r[gtpm_pkg::C_POS_IN]) begin
            mode_r <= gtpm_pkg::GTPM_FIXED; // see [R13]
          end else if (ctrl_r[gtpm_pkg::C_MODE +: 2] == gtpm_pkg::GTPM_SURVEY) begin
            mode_r <= gtpm_pkg::GTPM_SURVEY;
          end
        end
        gtpm_pkg::GTPM_SURVEY: begin
          if (ctrl_r[gtpm_pkg::C_SURV_OK] || ctrl_r[gtpm_pkg::C_POS_IN]) begin
            mode_r <= gtpm_pkg::GTPM_FIXED; // see [R13]
          end else if (ctrl_r[gtpm_pkg::C_MODE +: 2] == gtpm_pkg::GTPM_DISABLED) begin
            mode_r <= gtpm_pkg::GTPM_DISABLED;
          end
        end
        gtpm_pkg::GTPM_FIXED: begin
          if (ctrl_r[gtpm_pkg::C_MODE +: 2] == gtpm_pkg::GTPM_DISABLED
              && !ctrl_r[gtpm_pkg::C_POS_IN]) begin
            mode_r <= gtpm_pkg::GTPM_DISABLED;
          end
        end
        default: mode_r <= gtpm_pkg::GTPM_DISABLED;
      endcase
    end
  end
  assign fixed_ev = (mode_r == gtpm_pkg::GTPM_SURVEY) && ctrl_r[gtpm_pkg::C_SURV_OK];

  // Uncertainty with ambiguity terms; aiding clears them
  always_comb begin
    unc_tot = unc_r;
    if (!time_aiding_msg) begin // see [R16]
      if (amb_flags[0]) unc_tot = unc_tot + gtpm_pkg::AMB_EPOCH_NS; // see [R9]
      if (amb_flags[1]) unc_tot = unc_tot + gtpm_pkg::AMB_BIT_NS; // see [R9]
      if (amb_flags[2]) unc_tot = 32'hFFFF_FFFF; // see [R9]
    end
  end
  // Single signal allowed only in fixed mode
  assign gate_ok = (unc_tot <= limit_r) // see [R8]
    && (sig_used_r > 8'h01 || (mode_r == gtpm_pkg::GTPM_FIXED
    && ctrl_r[gtpm_pkg::C_SINGLE] && sig_used_r == 8'h01)); // see [R14]
  assign run0 = ctrl_r[gtpm_pkg::C_EN0] && gate_ok && !duty_off; // see [R10]
  assign run1 = ctrl_r[gtpm_pkg::C_EN1] && gate_ok && !duty_off; // see [R10]

  gtpm_pulse_gen #(.W(32)) u_tp0 (
    .clk(clk), .rst_b(rst_b), .ce(ce), .enable(run0),
    .half_period(per0_r), .phase_ofs(scale_time(ctrl_r[gtpm_pkg::C_UTC0], '0)),
    .pulse(p0), .rise(r0)
  );
  gtpm_pulse_gen #(.W(32)) u_tp1 (
    .clk(clk), .rst_b(rst_b), .ce(ce), .enable(run1),
    .half_period(per1_r), .phase_ofs(scale_time(ctrl_r[gtpm_pkg::C_UTC1], '0)),
    .pulse(p1), .rise(r1)
  );

  // Time base and pulse outputs
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      time_r <= '0;
      pulse_time_r <= '0;
      primary_pulse_out <= 1'b0;
      secondary_pulse_out <= 1'b0;
      phase_report <= 1'b0;
      integrity_active <= 1'b0;
    end else if (ce) begin
      time_r <= time_r + 32'h0000_0014; // 20 ns steps, see [R6]
      if (r0) pulse_time_r <= scale_time(ctrl_r[gtpm_pkg::C_UTC0], time_r); // see [R2] [R4]
      primary_pulse_out <= p0 & run0; // see [R18]
      secondary_pulse_out <= p1 & run1; // see [R18]
      // Slow rates: announce next phase at the falling half
      phase_report <= run0 && (per0_r > (gtpm_pkg::PER_1HZ >> 1)) && !p0; // see [R3]
      integrity_active <= sig_used_r > sig_min_r; // see [R15]
    end
  end

  // Event inputs: two-flop sync then edge detect
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ev_s1_r <= '0;
      ev_s2_r <= '0;
      ev_d_r <= '0;
    end else if (ce) begin
      ev_s1_r <= {event_input_b, event_input_a};
      ev_s2_r <= ev_s1_r;
      ev_d_r <= ev_s2_r;
    end
  end

  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_ev
      assign ev_edge[g].rise = ev_s2_r[g] & ~ev_d_r[g];
      assign ev_edge[g].fall = ~ev_s2_r[g] & ev_d_r[g];
      always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
          ts_r[2*g] <= '0;
          ts_r[2*g+1] <= '0;
          cnt_r[2*g] <= '0;
          cnt_r[2*g+1] <= '0;
        end else if (ce) begin
          if (ev_edge[g].rise) begin
            ts_r[2*g] <= scale_time(ctrl_r[gtpm_pkg::C_UTC0], time_r); // see [R5] [R7]
            cnt_r[2*g] <= cnt_r[2*g] + 8'h01; // see [R17]
          end
          if (ev_edge[g].fall) begin
            ts_r[2*g+1] <= scale_time(ctrl_r[gtpm_pkg::C_UTC0], time_r); // see [R5] [R7]
            cnt_r[2*g+1] <= cnt_r[2*g+1] + 8'h01; // see [R17]
          end
        end
      end
    end
  endgenerate

  // Interrupt status: set wins over clear
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      irq_st_r <= '0;
      irq <= 1'b0;
    end else if (ce) begin
      irq_st_r <= (irq_st_r & ~((wr && addr == gtpm_pkg::A_IRQ_CLR) ? wdata[4:0] : 5'h00))
        | {!gate_ok, fixed_ev, |ev_edge[1], |ev_edge[0], r0};
      irq <= |(irq_st_r & irq_en_r);
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rdata <= '0;
    end else if (ce) begin
      rdata <= '0;
      if (rd) begin
        case (addr)
          gtpm_pkg::A_CTRL: rdata <= ctrl_r;
          gtpm_pkg::A_PER0: rdata <= per0_r;
          gtpm_pkg::A_PER1: rdata <= per1_r;
          gtpm_pkg::A_UNC: rdata <= unc_tot;
          gtpm_pkg::A_LIMIT: rdata <= limit_r;
          gtpm_pkg::A_SIG: rdata <= {16'h0000, sig_min_r, sig_used_r};
          gtpm_pkg::A_TIME: rdata <= pulse_time_r; // see [R4]
          gtpm_pkg::A_STAT: rdata <= {28'h0000000, integrity_active, gate_ok, mode_r};
          gtpm_pkg::A_IRQ_ST: rdata <= {27'h0000000, irq_st_r};
          gtpm_pkg::A_IRQ_EN: rdata <= {27'h0000000, irq_en_r};
          gtpm_pkg::A_TS_AR: rdata <= ts_r[0];
          gtpm_pkg::A_TS_AF: rdata <= ts_r[1];
          gtpm_pkg::A_TS_BR: rdata <= ts_r[2];
          gtpm_pkg::A_TS_BF: rdata <= ts_r[3];
          gtpm_pkg::A_CNT: rdata <= {cnt_r[3], cnt_r[2], cnt_r[1], cnt_r[0]};
          default: rdata <= '0;
        endcase
      end
    end
  end

  a_pulse_gated: assert property (@(posedge clk) disable iff (!rst_b)
    ce && duty_off |=> !primary_pulse_out && !secondary_pulse_out) // see [R10]
    else $error("pulse driven during off phase");
  a_raim_flag: assert property (@(posedge clk) disable iff (!rst_b)
    ce |=> integrity_active == $past(sig_used_r > sig_min_r)) // see [R15]
    else $error("integrity flag mismatch");
  a_gate_limit: assert property (@(posedge clk) disable iff (!rst_b)
    ce && unc_tot > limit_r |=> !primary_pulse_out) // see [R8]
    else $error("pulse not gated by uncertainty");
  a_cnt_rise: assert property (@(posedge clk) disable iff (!rst_b)
    ce && ev_edge[0].rise |=> cnt_r[0] == $past(cnt_r[0]) + 8'h01) // see [R17]
    else $error("rise counter not advanced");
  a_ts_fall: assert property (@(posedge clk) disable iff (!rst_b)
    ce && ev_edge[1].fall |=> ts_r[3] == scale_time(ctrl_r[gtpm_pkg::C_UTC0], $past(time_r))) // see [R7]
    else $error("fall stamp wrong");
  a_single_sig: assert property (@(posedge clk) disable iff (!rst_b)
    sig_used_r == 8'h01 && mode_r != gtpm_pkg::GTPM_FIXED |-> !gate_ok) // see [R14]
    else $error("single signal outside fixed mode");
  a_survey_fix: assert property (@(posedge clk) disable iff (!rst_b)
    ce && fixed_ev |=> mode_r == gtpm_pkg::GTPM_FIXED) // see [R13]
    else $error("survey did not fix");
  a_pulse_time: assert property (@(posedge clk) disable iff (!rst_b)
    ce && r0 |=> pulse_time_r == scale_time(ctrl_r[gtpm_pkg::C_UTC0], $past(time_r))) // see [R4]
    else $error("pulse time not latched");
endmodule : gtpm_timing

// File: rtl/gtpm_pkg.sv
package gtpm_pkg;
  localparam int CLK_HZ = 50000000;
  // Register indices (byte address = index * 4 is not used; plain port)
  localparam logic [3:0] A_CTRL = 4'h0;
  localparam logic [3:0] A_PER0 = 4'h1;
  localparam logic [3:0] A_PER1 = 4'h2;
  localparam logic [3:0] A_UNC = 4'h3;
  localparam logic [3:0] A_LIMIT = 4'h4;
  localparam logic [3:0] A_SIG = 4'h5;
  localparam logic [3:0] A_TIME = 4'h6;
  localparam logic [3:0] A_STAT = 4'h7;
  localparam logic [3:0] A_IRQ_ST = 4'h8;
  localparam logic [3:0] A_IRQ_EN = 4'h9;
  localparam logic [3:0] A_IRQ_CLR = 4'hA;
  localparam logic [3:0] A_TS_AR = 4'hB;
  localparam logic [3:0] A_TS_AF = 4'hC;
  localparam logic [3:0] A_TS_BR = 4'hD;
  localparam logic [3:0] A_TS_BF = 4'hE;
  localparam logic [3:0] A_CNT = 4'hF;
  // Control fields
  localparam int C_EN0 = 0;
  localparam int C_EN1 = 1;
  localparam int C_UTC0 = 2;
  localparam int C_UTC1 = 3;
  localparam int C_MODE = 4;
  localparam int C_SURV_OK = 6;
  localparam int C_POS_IN = 7;
  localparam int C_SINGLE = 8;
  localparam logic [31:0] CTRL_RST = 32'h0000_0001;
  // 1 Hz at 50 MHz: half period in cycles
  localparam logic [31:0] PER_1HZ = 32'h017D_7840;
  localparam logic [31:0] PER_MIN = 32'h0000_0002;
  // Leap offset between civil and satellite scales, cycles (arbitrary default)
  localparam logic [31:0] UTC_OFS = 32'h0000_0000;
  // Ambiguity increments in ns
  localparam logic [31:0] AMB_EPOCH_NS = 32'h000F_4240;
  localparam logic [31:0] AMB_BIT_NS = 32'h0131_2D00;
  localparam logic [31:0] AMB_SUBF_NS = 32'h0000_0000;
  // Interrupt bits
  localparam int I_TP0 = 0;
  localparam int I_EVA = 1;
  localparam int I_EVB = 2;
  localparam int I_FIXED = 3;
  localparam int I_GATE = 4;
  typedef enum logic [1:0] {
    GTPM_DISABLED = 2'b00,
    GTPM_SURVEY = 2'b01,
    GTPM_FIXED = 2'b10
  } gtpm_mode_e;
  typedef struct packed {
    logic [31:0] addr_pad;
    logic [3:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } gtpm_bus_s;
  typedef struct packed {
    logic rise;
    logic fall;
  } gtpm_edge_s;
endpackage : gtpm_pkg

// File: rtl/gtpm_pulse_gen.sv
`timescale 1ns/1ps
module gtpm_pulse_gen #(
  parameter int W = 32
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic ce,
  input wire logic enable,
  input wire logic [W-1:0] half_period,
  input wire logic [W-1:0] phase_ofs,
  output logic pulse,
  output logic rise
);
  logic [W-1:0] cnt_r;
  logic [W-1:0] lim;
  assign lim = (half_period < gtpm_pkg::PER_MIN[W-1:0]) ? gtpm_pkg::PER_MIN[W-1:0] : half_period;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_r <= '0;
      pulse <= 1'b0;
      rise <= 1'b0;
    end else if (ce) begin
      rise <= 1'b0;
      if (!enable) begin
        cnt_r <= phase_ofs;
        pulse <= 1'b0;
      end else if (cnt_r >= lim - 1'b1) begin
        cnt_r <= '0;
        pulse <= ~pulse;
        rise <= ~pulse;
      end else begin
        cnt_r <= cnt_r + 1'b1;
      end
    end
  end
endmodule : gtpm_pulse_gen

// File: bench/gtpm_far_end.sv
`timescale 1ns/1ps
module gtpm_far_end (
  input wire logic clk,
  input wire logic secondary_pulse_out,
  output logic event_input_a,
  output logic event_input_b,
  output logic time_aiding_msg
);
  logic sec_load;
  initial begin
    event_input_a = 1'b0;
    event_input_b = 1'b0;
    time_aiding_msg = 1'b0;
  end
  // Passive load, never pulls the pin low
  assign sec_load = secondary_pulse_out;
  task automatic edges(input bit b, input int n, input bit aid);
    for (int i = 0; i < n; i++) begin
      @(posedge clk);
      if (b) begin
        event_input_b <= 1'b1;
      end else begin
        event_input_a <= 1'b1;
      end
      time_aiding_msg <= aid;
      repeat (4) @(posedge clk);
      event_input_a <= 1'b0;
      event_input_b <= 1'b0;
      repeat (4) @(posedge clk);
    end
  endtask : edges
endmodule : gtpm_far_end

// File: bench/testbench.sv
`timescale 1ns/1ps
module testbench;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [31:0] wdata = 32'h0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic duty_off = 1'b0;
  logic [2:0] amb_flags = 3'h0;
  logic [31:0] rdata;
  logic ev_a, ev_b, aid, p0, p1, phase, integ, irq, pls;
  logic sel = 1'b0;
  logic [31:0] v, t0;
  int num_errors = 0;
  int n_compared = 0;
  int n;
  assign pls = sel ? p1 : p0;
  always #10 clk = ~clk;
  gtpm_timing DUT (.clk(clk), .rst_b(rst_b), .ce(1'b1), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .event_input_a(ev_a), .event_input_b(ev_b),
    .duty_off(duty_off), .time_aiding_msg(aid), .amb_flags(amb_flags),
    .primary_pulse_out(p0), .secondary_pulse_out(p1), .phase_report(phase),
    .integrity_active(integ), .irq(irq));
  gtpm_far_end u_far (.clk(clk), .secondary_pulse_out(p1), .event_input_a(ev_a),
    .event_input_b(ev_b), .time_aiding_msg(aid));
  task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg
  task automatic rd_reg(input logic [3:0] a, output logic [31:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    d = rdata;
  endtask : rd_reg
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic chk_reg(input logic [3:0] a, input logic [31:0] exp);
    logic [31:0] d;
    rd_reg(a, d);
    chk(d, exp);
  endtask : chk_reg
  // Width of the next full high phase, in cycles
  task automatic high_len(input logic s, output int len);
    sel = s;
    len = 0;
    for (int i = 0; i < 200 && pls !== 1'b0; i++) @(negedge clk);
    for (int i = 0; i < 200 && pls !== 1'b1; i++) @(negedge clk);
    while (pls === 1'b1 && len < 200) begin
      @(negedge clk);
      len++;
    end
  endtask : high_len
  task automatic quiet(input logic s, input int cyc);
    int hi;
    hi = 0;
    sel = s;
    repeat (cyc) begin
      @(negedge clk);
      if (pls !== 1'b0) hi++;
    end
    chk(hi, 0);
  endtask : quiet
  task automatic complete_run;
    $display("Compared %0d, errors %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : complete_run
  initial begin
    repeat (50000) @(posedge clk);
    num_errors++;
    complete_run();
  end
  initial begin
    repeat (12) @(posedge clk);
    rst_b <= 1'b1;
    chk_reg(gtpm_pkg::A_CTRL, gtpm_pkg::CTRL_RST);
    chk_reg(gtpm_pkg::A_PER0, gtpm_pkg::PER_1HZ);
    chk({31'h0, phase}, 32'h1);
    chk({31'h0, p1}, 32'h0);
    wr_reg(gtpm_pkg::A_PER0, 32'h4);
    high_len(1'b0, n);
    chk(n, 32'h4);
    chk({31'h0, phase}, 32'h0);
    wr_reg(gtpm_pkg::A_PER1, 32'h3);
    wr_reg(gtpm_pkg::A_CTRL, 32'h3);
    high_len(1'b1, n);
    chk(n, 32'h3);
    duty_off <= 1'b1;
    repeat (10) @(posedge clk);
    quiet(1'b0, 30);
    duty_off <= 1'b0;
    // Edge stamps, counters, masked then enabled interrupt
    wr_reg(gtpm_pkg::A_IRQ_EN, 32'h0);
    u_far.edges(1'b0, 3, 1'b0);
    u_far.edges(1'b1, 2, 1'b0);
    repeat (5) @(posedge clk);
    chk_reg(gtpm_pkg::A_CNT, 32'h0202_0303);
    rd_reg(gtpm_pkg::A_TS_AR, t0);
    rd_reg(gtpm_pkg::A_TS_AF, v);
    // Stamps count in ns: four cycles high is 80 ns
    chk(v - t0, 32'h50);
    chk({31'h0, irq}, 32'h0);
    rd_reg(gtpm_pkg::A_IRQ_ST, v);
    chk({30'h0, v[2:1]}, 32'h3);
    wr_reg(gtpm_pkg::A_IRQ_EN, 32'h6);
    repeat (2) @(posedge clk);
    chk({31'h0, irq}, 32'h1);
    wr_reg(gtpm_pkg::A_IRQ_CLR, 32'h6);
    repeat (2) @(posedge clk);
    chk({31'h0, irq}, 32'h0);
    // Integrity flag and time mode
    wr_reg(gtpm_pkg::A_SIG, 32'h0405);
    repeat (2) @(posedge clk);
    chk({31'h0, integ}, 32'h1);
    wr_reg(gtpm_pkg::A_SIG, 32'h0404);
    repeat (2) @(posedge clk);
    chk({31'h0, integ}, 32'h0);
    wr_reg(gtpm_pkg::A_CTRL, 32'h13);
    wr_reg(gtpm_pkg::A_CTRL, 32'h53);
    repeat (2) @(posedge clk);
    rd_reg(gtpm_pkg::A_STAT, v);
    chk({30'h0, v[1:0]}, {30'h0, gtpm_pkg::GTPM_FIXED});
    wr_reg(gtpm_pkg::A_STAT, 32'hFFFF_FFFF);
    chk_reg(gtpm_pkg::A_STAT, v);
    // Unresolved sub-frame ambiguity fails the accuracy limit
    wr_reg(gtpm_pkg::A_LIMIT, 32'h3E8);
    wr_reg(gtpm_pkg::A_IRQ_EN, 32'h10);
    amb_flags <= 3'h4;
    repeat (10) @(posedge clk);
    quiet(1'b0, 30);
    quiet(1'b1, 30);
    chk({31'h0, irq}, 32'h1);
    rd_reg(gtpm_pkg::A_STAT, v);
    chk({31'h0, v[2]}, 32'h0);
    // Aiding pulse plus message resolves the ambiguity
    u_far.edges(1'b0, 1, 1'b1);
    repeat (10) @(posedge clk);
    high_len(1'b0, n);
    chk(n, 32'h4);
    wr_reg(gtpm_pkg::A_IRQ_CLR, 32'h10);
    repeat (2) @(posedge clk);
    chk({31'h0, irq}, 32'h0);
    complete_run();
  end
endmodule : testbench
